// *** multicore_pin_output.sv ***
// file: top of the multicore wired-OR pin output block with its APB slave
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns

// Contract
// - 32-bit latch, bit n drives pin n
// - latch 0 drives low, 1 drives high
// - starting a core clears its latch
// - each core owns a freely written latch
// - pin level is OR of all cores
// - latch OR sources, then AND direction
// - direction bit 0 ignores that output
// - disabled core counts as direction zero
// - second port latch reserved, no pins
// - latch read returns latch, not pins
module multicore_pin_output
	import pinout_pkg::*;
#(
	parameter int unsigned WIDTH = PIN_COUNT,  // pins per port
	parameter int unsigned CORES = CORE_COUNT  // cores sharing the port
) (
	input  wire logic             i_clock,     // system clock
	input  wire logic             i_reset,     // async reset, high
	input  wire logic             i_psel,      // apb select
	input  wire logic             i_penable,   // apb enable
	input  wire logic             i_pwrite,    // apb write
	input  wire logic [11:0]      i_paddr,     // apb byte address
	input  wire logic [31:0]      i_pwdata,    // apb write data
	input  wire logic [3:0]       i_pstrb,     // apb byte strobes
	output logic      [31:0]      o_prdata,    // apb read data
	output logic                  o_pready,    // apb ready
	output logic                  o_pslverr,   // apb error
	output logic      [WIDTH-1:0] o_pin_out,   // pin output level
	output logic      [WIDTH-1:0] o_pin_oe     // pin output enable
);

	// ==========================================
	// per-core wires
	logic [WIDTH-1:0] latch   [CORES];  // stored latches
	logic [WIDTH-1:0] dir     [CORES];  // stored directions
	logic [WIDTH-1:0] aux     [CORES];  // stored other sources
	logic             run     [CORES];  // enables
	logic [WIDTH-1:0] eff_out [CORES];  // effective outputs
	logic [WIDTH-1:0] eff_dir [CORES];  // effective directions
	logic [CORES-1:0] wr_out;           // latch write strobes
	logic [CORES-1:0] wr_dir;           // direction write strobes
	logic [CORES-1:0] wr_aux;           // source write strobes
	logic [CORES-1:0] wr_ctrl;          // control write strobes

	// ==========================================
	// bus state
	typedef struct packed {
		logic [31:0] rdata;  // read data
		logic        err;    // error flag
	} bus_state_t;

	bus_state_t state_r;   // registered
	bus_state_t state_nxt; // next

	// address decode result
	typedef struct packed {
		logic                  hit;     // mapped
		logic                  glob;    // global register
		logic [CORE_SEL_W-1:0] core;    // core index
		logic [4:0]            ofs;     // offset inside core block
	} dec_t;

	// decode a byte address, used for reads and writes
	function automatic dec_t decode(input logic [11:0] a);
		dec_t d;
		d = '0;
		d.core = a[5 +: CORE_SEL_W];
		d.ofs  = a[4:0];
		if (a == OFS_PIN_OUT || a == OFS_PIN_OE) begin
			d.hit  = 1'b1;
			d.glob = 1'b1;
		end else if (a < 12'(CORE_STRIDE * CORES)) begin
			d.hit = (d.ofs == OFS_OUT_A) || (d.ofs == OFS_OUT_B) || (d.ofs == OFS_DIR_A)
				|| (d.ofs == OFS_AUX_OUT) || (d.ofs == OFS_CORE_CTRL);
		end
		return d;
	endfunction : decode

	dec_t        dec;      // current decode
	logic        acc;      // access phase
	logic [31:0] rd_mux;   // read value

	assign dec = decode(i_paddr);
	assign acc = i_psel && i_penable;

	// ==========================================
	// write strobes, one per core and register
	always_comb begin
		wr_out  = '0;
		wr_dir  = '0;
		wr_aux  = '0;
		wr_ctrl = '0;
		if (acc && i_pwrite && dec.hit && !dec.glob) begin
			case (dec.ofs)
				OFS_OUT_A:     wr_out[dec.core]  = 1'b1;
				OFS_DIR_A:     wr_dir[dec.core]  = 1'b1;
				OFS_AUX_OUT:   wr_aux[dec.core]  = 1'b1;
				OFS_CORE_CTRL: wr_ctrl[dec.core] = 1'b1;
				default:       ; // second port writes dropped
			endcase
		end
	end

	// ==========================================
	// read mux
	always_comb begin
		rd_mux = RSVD_VALUE;
		if (dec.glob) begin
			rd_mux = (i_paddr == OFS_PIN_OUT) ? 32'(o_pin_out) : 32'(o_pin_oe);
		end else begin
			case (dec.ofs)
				OFS_OUT_A:     rd_mux = 32'(latch[dec.core]);
				OFS_DIR_A:     rd_mux = 32'(dir[dec.core]);
				OFS_AUX_OUT:   rd_mux = 32'(aux[dec.core]);
				OFS_CORE_CTRL: rd_mux = {31'h0, run[dec.core]};
				default:       rd_mux = RSVD_VALUE;
			endcase
		end
	end

	// next bus state, read data registered in setup phase
	always_comb begin
		state_nxt = state_r;
		if (i_psel && !i_penable) begin
			state_nxt.rdata = (dec.hit && !i_pwrite) ? rd_mux : 32'h0000_0000;
			state_nxt.err   = !dec.hit || (i_pwrite && dec.glob);
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_pready  = 1'b1;
	assign o_prdata  = state_r.rdata;
	assign o_pslverr = acc && state_r.err;

	// ==========================================
	// one register set per core
	for (genvar c = 0; c < CORES; c++) begin : g_core
		core_port_regs #(
			.WIDTH(WIDTH)
		) u_regs (
			.i_clock   (i_clock),
			.i_reset   (i_reset),
			.i_wr_out  (wr_out[c]),
			.i_wr_dir  (wr_dir[c]),
			.i_wr_aux  (wr_aux[c]),
			.i_wr_ctrl (wr_ctrl[c]),
			.i_wdata   (i_pwdata),
			.i_strb    (i_pstrb),
			.o_latch   (latch[c]),
			.o_dir     (dir[c]),
			.o_aux     (aux[c]),
			.o_run     (run[c]),
			.o_eff_out (eff_out[c]),
			.o_eff_dir (eff_dir[c])
		);
	end

	// ==========================================
	// wired-OR onto the pins
	pin_merge #(
		.WIDTH(WIDTH),
		.CORES(CORES)
	) u_merge (
		.i_clock   (i_clock),
		.i_reset   (i_reset),
		.i_out     (eff_out),
		.i_dir     (eff_dir),
		.o_pin_out (o_pin_out),
		.o_pin_oe  (o_pin_oe)
	);

endmodule : multicore_pin_output

// *** pinout_pkg.sv ***
// package: register map, reset values and sizes of the multicore pin output block
package pinout_pkg;

	// ==========================================
	// sizes
	localparam int unsigned PIN_COUNT      = 32;           // pins of the port
	localparam int unsigned CORE_COUNT     = 8;            // number of cores
	localparam int unsigned CORE_SEL_W     = 3;            // bits to pick a core

	// ==========================================
	// register map, per core block of 0x20 bytes
	localparam logic [11:0] CORE_STRIDE    = 12'h020;      // byte span of one core
	localparam logic [4:0]  OFS_OUT_A      = 5'h00;        // port_a_output_latch
	localparam logic [4:0]  OFS_OUT_B      = 5'h04;        // port_b_output_latch, reserved
	localparam logic [4:0]  OFS_DIR_A      = 5'h08;        // port_a_direction_reg
	localparam logic [4:0]  OFS_AUX_OUT    = 5'h0c;        // other internal output sources
	localparam logic [4:0]  OFS_CORE_CTRL  = 5'h10;        // bit0 run, write 1 to bit1 to start
	localparam logic [11:0] OFS_PIN_OUT    = 12'h100;      // combined pin level, read only
	localparam logic [11:0] OFS_PIN_OE     = 12'h104;      // combined pin enable, read only

	// ==========================================
	// field positions and reset values
	localparam int unsigned CTRL_RUN_BIT   = 0;            // core enabled
	localparam int unsigned CTRL_START_BIT = 1;            // start strobe, reads zero
	localparam logic [31:0] OUT_RESET      = 32'h0000_0000;
	localparam logic [31:0] DIR_RESET      = 32'h0000_0000;
	localparam logic [31:0] RSVD_VALUE     = 32'h0000_0000;

endpackage : pinout_pkg

// *** core_port_regs.sv ***
// file: per-core latch, direction and source registers with effective output
`timescale 1ns/1ns
module core_port_regs
	import pinout_pkg::*;
#(
	parameter int unsigned WIDTH = PIN_COUNT   // pins covered
) (
	input  wire logic             i_clock,     // system clock
	input  wire logic             i_reset,     // async reset, high
	input  wire logic             i_wr_out,    // write output latch
	input  wire logic             i_wr_dir,    // write direction
	input  wire logic             i_wr_aux,    // write other sources
	input  wire logic             i_wr_ctrl,   // write control
	input  wire logic [31:0]      i_wdata,     // write data
	input  wire logic [3:0]       i_strb,      // byte enables
	output logic      [WIDTH-1:0] o_latch,     // stored latch
	output logic      [WIDTH-1:0] o_dir,       // stored direction
	output logic      [WIDTH-1:0] o_aux,       // stored other sources
	output logic                  o_run,       // core enabled
	output logic      [WIDTH-1:0] o_eff_out,   // effective output
	output logic      [WIDTH-1:0] o_eff_dir    // effective direction
);

	// ==========================================
	// state
	typedef struct packed {
		logic [WIDTH-1:0] latch;   // output latch
		logic [WIDTH-1:0] dir;     // direction
		logic [WIDTH-1:0] aux;     // other sources
		logic             run;     // enabled
	} core_state_t;

	core_state_t state_r;   // registered state
	core_state_t state_nxt; // next state

	// byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	// ==========================================
	// next state
	always_comb begin
		state_nxt = state_r;
		if (i_wr_out) begin
			state_nxt.latch = merge(state_r.latch, i_wdata, i_strb);
		end
		if (i_wr_dir) begin
			state_nxt.dir = merge(state_r.dir, i_wdata, i_strb);
		end
		if (i_wr_aux) begin
			state_nxt.aux = merge(state_r.aux, i_wdata, i_strb);
		end
		if (i_wr_ctrl && i_strb[0]) begin
			state_nxt.run = i_wdata[CTRL_RUN_BIT] | i_wdata[CTRL_START_BIT];
			if (i_wdata[CTRL_START_BIT]) begin
				state_nxt.latch = OUT_RESET;
			end
		end
	end

	// register
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			state_r <= '{latch: OUT_RESET, dir: DIR_RESET, aux: '0, run: 1'b0};
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================
	// outputs
	assign o_latch   = state_r.latch;
	assign o_dir     = state_r.dir;
	assign o_aux     = state_r.aux;
	assign o_run     = state_r.run;
	assign o_eff_dir = state_r.run ? state_r.dir : '0;
	assign o_eff_out = (state_r.latch | state_r.aux) & o_eff_dir;

endmodule : core_port_regs

// *** pin_merge.sv ***
// file: wired-OR merge of every core's output and direction onto the pins
`timescale 1ns/1ns
module pin_merge
	import pinout_pkg::*;
#(
	parameter int unsigned WIDTH = PIN_COUNT,  // pins
	parameter int unsigned CORES = CORE_COUNT  // cores
) (
	input  wire logic             i_clock,     // system clock
	input  wire logic             i_reset,     // async reset, high
	input  wire logic [WIDTH-1:0] i_out [CORES], // effective outputs
	input  wire logic [WIDTH-1:0] i_dir [CORES], // effective directions
	output logic      [WIDTH-1:0] o_pin_out,   // pin level
	output logic      [WIDTH-1:0] o_pin_oe     // pin driver enable
);

	// ==========================================
	// state
	typedef struct packed {
		logic [WIDTH-1:0] lvl;   // merged level
		logic [WIDTH-1:0] oe;    // merged enable
	} merge_state_t;

	merge_state_t state_r;   // registered
	merge_state_t state_nxt; // next

	// or-reduce across cores
	always_comb begin
		state_nxt = '0;
		for (int c = 0; c < CORES; c++) begin
			state_nxt.lvl = state_nxt.lvl | i_out[c];
			state_nxt.oe  = state_nxt.oe | i_dir[c];
		end
	end

	// register the pin drive
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_pin_out = state_r.lvl;
	assign o_pin_oe  = state_r.oe;

endmodule : pin_merge

// *** multicore_pin_output_asserts.sv ***
// checker: bus and pin timing properties of the pin output block
`timescale 1ns/1ns
module multicore_pin_output_asserts
	import pinout_pkg::*;
#(
	parameter int unsigned WIDTH = PIN_COUNT,  // pins
	parameter int unsigned CORES = CORE_COUNT  // cores
) (
	input wire logic             i_clock,
	input wire logic             i_reset,
	input wire logic             i_psel,
	input wire logic             i_penable,
	input wire logic             i_pwrite,
	input wire logic [11:0]      i_paddr,
	input wire logic [31:0]      i_pwdata,
	input wire logic [3:0]       i_pstrb,
	input wire logic [31:0]      o_prdata,
	input wire logic             o_pready,
	input wire logic             o_pslverr,
	input wire logic [WIDTH-1:0] o_pin_out,
	input wire logic [WIDTH-1:0] o_pin_oe
);
	// ==========================================
	// access phase decode
	wire acc = i_psel && i_penable;  // access cycle
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);
	sequence s_idle;
		!(acc && i_pwrite);
	endsequence
	property p_ready; acc |-> o_pready; endproperty
	property p_noerr; !acc |-> !o_pslverr; endproperty
	property p_ro; acc && i_pwrite && i_paddr[11:8] == 4'h1 |-> o_pslverr; endproperty
	property p_map;
		acc && (i_paddr >= 12'h108 || (i_paddr < 12'h100 && i_paddr[4:0] >= 5'h14))
		|-> o_pslverr;
	endproperty
	property p_rsvd;
		acc && !i_pwrite && i_paddr < 12'h100 && i_paddr[4:0] == 5'h04 |-> o_prdata == 32'h0;
	endproperty
	property p_gate; (o_pin_out & ~o_pin_oe) == '0; endproperty
	property p_hold; s_idle |-> ##2 $stable(o_pin_out) && $stable(o_pin_oe); endproperty
	property p_rst; $fell(i_reset) |-> o_pin_out == '0 && o_pin_oe == '0; endproperty
	a_ready: assert property (p_ready) else $error("pready low in access");
	a_noerr: assert property (p_noerr) else $error("pslverr outside access");
	a_ro: assert property (p_ro) else $error("pin register write not refused");
	a_map: assert property (p_map) else $error("unmapped access not refused");
	a_rsvd: assert property (p_rsvd) else $error("reserved latch read nonzero");
	a_gate: assert property (p_gate) else $error("level on undriven pin");
	a_hold: assert property (p_hold) else $error("pins moved without write");
	a_rst: assert property (p_rst) else $error("pins not clear after reset");
endmodule : multicore_pin_output_asserts

bind multicore_pin_output multicore_pin_output_asserts #(.WIDTH(WIDTH), .CORES(CORES)) u_chk (
	.i_clock(i_clock), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));

// *** pin_board.sv ***
// model: board pins, floating lines wander when nobody drives them
`timescale 1ns/1ns
module pin_board (
	input  wire logic        i_clock,    // system clock
	input  wire logic [31:0] i_pin_out,  // driven level
	input  wire logic [31:0] i_pin_oe,   // driver enable
	output logic      [31:0] o_level     // level seen on board
);
	logic [31:0] float_r = 32'h5555_aaaa;  // no pull, toggles each cycle
	always_ff @(posedge i_clock) begin
		float_r <= ~float_r;
	end
	assign o_level = (i_pin_out & i_pin_oe) | (float_r & ~i_pin_oe);
endmodule : pin_board

// *** multicore_pin_output_tb_top.sv ***
// testbench: bus driven checks of the multicore pin output block
`timescale 1ns/1ns
module multicore_pin_output_tb_top import pinout_pkg::*;;
	logic        clock, reset, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, pin_out, pin_oe, level;
	logic [3:0]  pstrb;
	int          err_total, n_checks, cyc;
	multicore_pin_output dut (.i_clock(clock), .i_reset(reset), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.o_pin_out(pin_out), .o_pin_oe(pin_oe));
	pin_board board (.i_clock(clock), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_level(level));
	initial begin
		clock = 0;
		forever #4 clock = ~clock;
	end
	// ==========================================
	// helpers
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_sim
	// one apb transfer, setup then access until pready
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clock);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0; penable <= 0;
	endtask : xfer
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		xfer(1'b1, a, d, r, e);
		chk($sformatf("err wr %h", a), {31'h0, e}, 32'h0);
	endtask : wr
	task rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		xfer(1'b0, a, 32'h0, r, e);
		chk($sformatf("reg %h", a), r, exp);
	endtask : rd
	// pins settle one edge after the write edge, checked after two
	task pins(input logic [31:0] eo, input logic [31:0] eoe);
		repeat (2) @(posedge clock);
		#1;
		chk("pin level", level & eoe, eo);
		chk("pin oe", pin_oe, eoe);
	endtask : pins
	function logic [11:0] ra(input int c, input logic [4:0] o);
		return 12'(c) * CORE_STRIDE + 12'(o);
	endfunction : ra
	// timeout guard
	always @(posedge clock) begin
		cyc++;
		if (cyc > 4000) begin
			err_total++;
			end_sim();
		end
	end
	// ==========================================
	// tests
	initial begin
		logic [31:0] r;
		logic        e;
		reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 4'hf;
		repeat (12) @(posedge clock);
		reset <= 0;
		rd(ra(0, OFS_OUT_A), OUT_RESET);
		rd(ra(0, OFS_DIR_A), DIR_RESET);
		rd(OFS_PIN_OE, 32'h0);
		$display("test reset done");
		for (int c = 0; c < CORE_COUNT; c++) wr(ra(c, OFS_OUT_A), 32'h0101_0101 * c);
		for (int c = 0; c < CORE_COUNT; c++) rd(ra(c, OFS_OUT_A), 32'h0101_0101 * c);
		pstrb <= 4'h2;
		wr(ra(3, OFS_OUT_A), 32'hffff_ffff);
		pstrb <= 4'hf;
		rd(ra(3, OFS_OUT_A), 32'h0303_ff03);
		$display("test latches done");
		wr(ra(0, OFS_CORE_CTRL), 32'h2);
		wr(ra(1, OFS_CORE_CTRL), 32'h2);
		rd(ra(1, OFS_OUT_A), 32'h0);
		wr(ra(0, OFS_DIR_A), 32'h0430_01f0);
		wr(ra(0, OFS_OUT_A), 32'h4430_0190);
		wr(ra(2, OFS_DIR_A), 32'hf000_0000);
		wr(ra(2, OFS_OUT_A), 32'hf000_0000);
		pins(32'h0430_0190, 32'h0430_01f0);
		rd(ra(0, OFS_OUT_A), 32'h4430_0190);
		wr(ra(1, OFS_DIR_A), 32'hf);
		wr(ra(1, OFS_OUT_A), 32'h5);
		wr(ra(1, OFS_AUX_OUT), 32'h2);
		pins(32'h0430_0197, 32'h0430_01ff);
		rd(OFS_PIN_OUT, 32'h0430_0197);
		rd(ra(1, OFS_AUX_OUT), 32'h2);
		rd(ra(1, OFS_CORE_CTRL), 32'h1);
		$display("test merge done");
		wr(ra(1, OFS_CORE_CTRL), 32'h0);
		pins(32'h0430_0190, 32'h0430_01f0);
		rd(ra(1, OFS_DIR_A), 32'hf);
		wr(ra(0, OFS_CORE_CTRL), 32'h2);
		rd(ra(0, OFS_OUT_A), 32'h0);
		pins(32'h0, 32'h0430_01f0);
		$display("test restart done");
		wr(ra(0, OFS_OUT_B), 32'hffff_ffff);
		rd(ra(0, OFS_OUT_B), RSVD_VALUE);
		xfer(1'b0, 12'h014, 32'h0, r, e);
		chk("unmapped err", {31'h0, e}, 32'h1);
		chk("unmapped data", r, 32'h0);
		xfer(1'b1, OFS_PIN_OUT, 32'hffff_ffff, r, e);
		chk("ro err", {31'h0, e}, 32'h1);
		rd(OFS_PIN_OE, 32'h0430_01f0);
		$display("test refusal done");
		end_sim();
	end
endmodule : multicore_pin_output_tb_top
